/* hdl/audio_rx_pkg.sv */
// constants, field layouts and carrier types of the serial audio receiver
// assumes a single clock domain; pins arrive unsynchronised
package audio_rx_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_LEFT_VOL  = 8'h00;
    localparam logic [7:0] ADDR_RIGHT_VOL = 8'h04;
    localparam logic [7:0] ADDR_SRATE     = 8'h08;
    localparam logic [7:0] ADDR_FORMAT    = 8'h0c;
    localparam logic [7:0] ADDR_SOFT_RST  = 8'h10;
    localparam logic [7:0] ADDR_LEFT_WORD = 8'h14;
    localparam logic [7:0] ADDR_RIGHT_WRD = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1c;
    localparam logic [7:0] ADDR_PERIOD    = 8'h20;
    // volume register fields
    localparam int VOL_ZC_BIT   = 7;
    localparam int VOL_LINK_BIT = 8;
    localparam logic [8:0] VOL_RESET      = 9'h0_0f9;
    localparam logic [6:0] VOL_MUTE_LIMIT = 7'h30;
    // sample rate register fields
    localparam int SR_MODE_BIT   = 0;
    localparam int SR_OVERSAMPLING_BASE_SELECT_BIT   = 1;
    localparam int SR_CODE_LSB   = 2;
    localparam int SR_HALVER_BIT = 6;
    localparam int SR_CLKDIV_BIT = 7;
    localparam logic [8:0] SRATE_RESET = 9'h0_000;
    localparam logic [8:0] SRATE_MASK  = 9'h0_0ff;
    // format register fields
    localparam int FMT_WL_LSB    = 2;
    localparam int FMT_PHASE_BIT = 4;
    localparam int FMT_MS_BIT    = 6;
    localparam logic [6:0] FORMAT_RESET = 7'h01;
    localparam logic [6:0] FORMAT_MASK  = 7'h5f;
    // frame format codes
    localparam logic [1:0] FMT_RIGHT_J = 2'b00;
    localparam logic [1:0] FMT_LEFT_J  = 2'b01;
    localparam logic [1:0] FMT_I2S     = 2'b10;
    localparam logic [1:0] FMT_DSP     = 2'b11;
    // word length codes
    localparam logic [1:0] WL_16 = 2'b00;
    localparam logic [1:0] WL_20 = 2'b01;
    localparam logic [1:0] WL_24 = 2'b10;
    // oversampling ratios
    localparam logic [15:0] OS_USB_0    = 16'h00fa;
    localparam logic [15:0] OS_USB_1    = 16'h0110;
    localparam logic [15:0] OS_NORMAL_0 = 16'h0100;
    localparam logic [15:0] OS_NORMAL_1 = 16'h0180;
    // master bit clock half periods in clk cycles, and bit clocks per frame half
    localparam logic [2:0] HALF_NORMAL = 3'h2;
    localparam logic [2:0] HALF_FAST   = 3'h1;
    localparam logic [5:0] BITS_PER_HALF = 6'h20;

    typedef struct packed {
        logic bclk;
        logic frame_sync;
        logic data;
    } serial_in_t;

    typedef struct packed {
        logic bclk;
        logic bclk_oe_n;
        logic frame_sync;
        logic frame_sync_oe_n;
    } serial_out_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] left;
        logic [31:0] right;
    } sample_t;

    typedef struct packed {
        logic [6:0] gain;
        logic       mute;
    } headphone_t;
endpackage

/* hdl/stereo_dac_serial_audio_rx.sv */
// serial audio receiver with APB registers, clock control and volume
// assumes clk is the master clock; bclk and frame sync pins are async
// Behaviour
// [R1] words are MSB first, 16 to 32 bits; right-justified caps at 24
// [R2] master drives bit clock; slave takes it from the host as input
// [R3] right-justified: LSB sent on the rise before frame sync falls
// [R4] left-justified: MSB sent on the rise after frame sync rises
// [R5] i2s: MSB on second rise after frame sync falls, one bit late
// [R6] dsp: host frame sync drives the pin; its fall starts a frame
// [R7] dsp: left word first, right word follows with no gap
// [R8] master mode derives all clocks and rates from the master clock
// [R9] slave rate follows master clock and sample rate register
// [R10] rate code at D5..D2, oversampling D1, mode D0, resets to zero
// [R11] output divider bit only affects clock out: pass or halve
// [R12] halver bit runs the rate generator at half master clock
// [R13] oversampling bit: usb 250/272, normal 256/384 times fs
// [R14] mode bit 0 normal, 1 usb; changes code interpretation
// [R15] usb mode rate codes give 96 down to 8 khz at 12 mhz
// [R16] normal mode rate set depends on master clock frequency
// [R17] gain code steps 1 db from +6 db to -73 db per channel
// [R18] writing zero volume code mutes that headphone output
// [R19] zero-cross enabled: update waits for near ground, no timeout
// [R20] link bit copies a volume write to the other channel
// [R21] format 11 dsp, 10 i2s, 01 left-justified, 00 right-justified
// [R22] word length 00 16, 01 20, 10 24, 11 32 bits
// [R23] master normal mode bit clock is clk/4, fast at 88.2/96 khz
// [R24] phase bit 0: right while sync high; 1: right while sync low
// [R25] both words of a frame are handed on together once per frame
`timescale 1ns/1ps
module stereo_dac_serial_audio_rx (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // serial link
    input  wire audio_rx_pkg::serial_in_t serial_in,
    output audio_rx_pkg::serial_out_t     serial_out,
    // analog zero-cross comparators
    input  wire logic                     left_zero_near,
    input  wire logic                     right_zero_near,
    // converter path and headphone gain
    output audio_rx_pkg::sample_t         sample_out,
    output audio_rx_pkg::headphone_t      left_headphone_output,
    output audio_rx_pkg::headphone_t      right_headphone_output,
    // clock output pad control
    output logic                          clock_out_div2,
    output logic                          clock_output_divider
);
    import audio_rx_pkg::*;

    typedef struct packed {
        logic [2:0]  bclk_s;
        logic [2:0]  fs_s;
        logic [2:0]  din_s;
        logic [2:0]  zl_s;
        logic [2:0]  zr_s;
        logic        bclk_lvl;
        logic        fs_lvl;
        logic        din_lvl;
        logic        zl_lvl;
        logic        zr_lvl;
        logic [8:0]  lvol;
        logic [8:0]  rvol;
        logic [8:0]  srate;
        logic [6:0]  fmt;
        logic [6:0]  app_l;
        logic [6:0]  app_r;
        logic        pend_l;
        logic        pend_r;
        logic [2:0]  gen_cnt;
        logic        gen_bclk;
        logic        gen_fs;
        logic [5:0]  gen_bits;
        logic        gen_half;
        logic        prev_bclk;
        logic        prev_fs;
        logic [6:0]  bitcnt;
        logic [31:0] shift;
        logic [31:0] word_l;
        logic [31:0] word_r;
        logic        out_valid;
        logic [31:0] out_l;
        logic [31:0] out_r;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        clkdiv;
    } state_t;

    state_t s_q;
    state_t s_d;

    // effective word length in bits
    function automatic logic [6:0] word_bits(input logic [1:0] wl,
                                             input logic [1:0] f);
        unique case (wl)
            WL_16:   word_bits = 7'd16;
            WL_20:   word_bits = 7'd20;
            WL_24:   word_bits = 7'd24;
            default: word_bits = (f == FMT_RIGHT_J) ? 7'd24 : 7'd32; // [R1]
        endcase
    endfunction

    function automatic logic [31:0] word_mask(input logic [6:0] n);
        word_mask = (n >= 7'd32) ? 32'hffff_ffff
                                 : ((32'h0000_0001 << n[4:0]) - 32'h0000_0001);
    endfunction

    // master clock cycles per sample
    function automatic logic [15:0] sample_period(input logic [8:0] r);
        logic [15:0] os;
        logic [15:0] p;
        logic [3:0]  code;
        os = 16'h0000;
        p = 16'h0000;
        code = r[SR_CODE_LSB +: 4];
        if (r[SR_MODE_BIT]) begin // [R14]
            os = r[SR_OVERSAMPLING_BASE_SELECT_BIT] ? OS_USB_1 : OS_USB_0; // [R13]
        end else begin
            os = r[SR_OVERSAMPLING_BASE_SELECT_BIT] ? OS_NORMAL_1 : OS_NORMAL_0; // [R13]
        end
        unique case (code) // [R15] [R16] [R9]
            4'h7, 4'hf: p = os >> 1;
            4'h6:       p = os + (os >> 1);
            4'h3, 4'hb: p = os * 16'h0006;
            default:    p = os;
        endcase
        sample_period = r[SR_HALVER_BIT] ? (p << 1) : p; // [R12]
    endfunction

    // true in usb mode or when the rate code selects the 88.2 or 96 khz family
    function automatic logic fast_rate(input logic [8:0] r);
        fast_rate = r[SR_MODE_BIT] ||
                    (r[SR_CODE_LSB +: 4] == 4'h7) ||
                    (r[SR_CODE_LSB +: 4] == 4'hf);
    endfunction

    always_comb begin
        logic [1:0]  f;
        logic [6:0]  wb;
        logic        ms;
        logic        phase;
        logic        bclk_v;
        logic        fs_v;
        logic        brise;
        logic        fs_chg;
        logic        right_now;
        logic [31:0] nsh;
        logic [6:0]  cnt;
        logic [2:0]  half;
        logic        wr;
        logic        rd;
        logic        got_right;
        f = 2'b00;
        wb = 7'd0;
        ms = 1'b0;
        phase = 1'b0;
        bclk_v = 1'b0;
        fs_v = 1'b0;
        brise = 1'b0;
        fs_chg = 1'b0;
        right_now = 1'b0;
        nsh = 32'h0000_0000;
        cnt = 7'd0;
        half = 3'd0;
        wr = 1'b0;
        rd = 1'b0;
        got_right = 1'b0;
        s_d = s_q;

        // pin synchronisers, a change counts once stages two and three agree
        s_d.bclk_s = {s_q.bclk_s[1:0], serial_in.bclk};
        s_d.fs_s = {s_q.fs_s[1:0], serial_in.frame_sync};
        s_d.din_s = {s_q.din_s[1:0], serial_in.data};
        s_d.zl_s = {s_q.zl_s[1:0], left_zero_near};
        s_d.zr_s = {s_q.zr_s[1:0], right_zero_near};
        if (s_q.bclk_s[2] == s_q.bclk_s[1]) s_d.bclk_lvl = s_q.bclk_s[2];
        if (s_q.fs_s[2] == s_q.fs_s[1]) s_d.fs_lvl = s_q.fs_s[2];
        if (s_q.din_s[2] == s_q.din_s[1]) s_d.din_lvl = s_q.din_s[2];
        if (s_q.zl_s[2] == s_q.zl_s[1]) s_d.zl_lvl = s_q.zl_s[2];
        if (s_q.zr_s[2] == s_q.zr_s[1]) s_d.zr_lvl = s_q.zr_s[2];

        f = s_q.fmt[1:0]; // [R21]
        wb = word_bits(s_q.fmt[FMT_WL_LSB +: 2], f); // [R22]
        ms = s_q.fmt[FMT_MS_BIT];
        phase = s_q.fmt[FMT_PHASE_BIT];

        // master bit clock and frame sync generator
        half = fast_rate(s_q.srate) ? HALF_FAST : HALF_NORMAL; // [R23] [R8]
        if (s_q.srate[SR_HALVER_BIT]) half = half << 1; // [R12]
        if (s_q.gen_cnt + 3'd1 >= half) begin
            s_d.gen_cnt = 3'd0;
            s_d.gen_bclk = ~s_q.gen_bclk;
            if (s_q.gen_bclk) begin
                if (s_q.gen_bits == BITS_PER_HALF - 6'd1) begin
                    s_d.gen_bits = 6'd0;
                    s_d.gen_half = ~s_q.gen_half;
                end else begin
                    s_d.gen_bits = s_q.gen_bits + 6'd1;
                end
                if (f == FMT_DSP) begin
                    // one low bit marks the frame start
                    s_d.gen_fs = ~((s_d.gen_bits == 6'd0) && !s_d.gen_half);
                end else begin
                    s_d.gen_fs = s_d.gen_half;
                end
            end
        end else begin
            s_d.gen_cnt = s_q.gen_cnt + 3'd1;
        end
        s_d.clkdiv = ~s_q.clkdiv; // [R11]

        // source of bit clock and frame sync
        bclk_v = ms ? s_q.gen_bclk : s_q.bclk_lvl; // [R2]
        fs_v = ms ? s_q.gen_fs : s_q.fs_lvl; // [R6]
        s_d.prev_bclk = bclk_v;
        brise = bclk_v && !s_q.prev_bclk;
        s_d.out_valid = 1'b0;

        // receiver, sampling data on bit clock rises
        if (brise) begin
            s_d.prev_fs = fs_v;
            fs_chg = (fs_v != s_q.prev_fs);
            right_now = fs_v ^ phase; // [R24]
            nsh = {s_q.shift[30:0], s_q.din_lvl}; // [R1]
            cnt = (s_q.bitcnt == 7'h7f) ? s_q.bitcnt : s_q.bitcnt + 7'd1;
            unique case (f)
                FMT_RIGHT_J: begin
                    if (fs_chg) begin
                        // previous half ended with its LSB
                        if (!right_now) begin // [R3]
                            s_d.word_r = s_q.shift & word_mask(wb);
                            got_right = 1'b1;
                        end else begin
                            s_d.word_l = s_q.shift & word_mask(wb);
                        end
                    end
                    s_d.shift = nsh;
                end
                FMT_LEFT_J, FMT_I2S: begin
                    if (fs_chg) cnt = 7'd0;
                    s_d.shift = nsh;
                    // word ends w-1 slots in, one later for i2s
                    if ((f == FMT_LEFT_J && cnt == wb - 7'd1) || // [R4]
                        (f == FMT_I2S && cnt == wb)) begin // [R5]
                        if (right_now) begin
                            s_d.word_r = nsh & word_mask(wb);
                            got_right = 1'b1;
                        end else begin
                            s_d.word_l = nsh & word_mask(wb);
                        end
                    end
                end
                FMT_DSP: begin
                    if (fs_chg && !fs_v) cnt = 7'd0; // [R6]
                    s_d.shift = nsh;
                    if (cnt == wb - 7'd1) begin // [R7]
                        s_d.word_l = nsh & word_mask(wb);
                    end else if (cnt == (wb << 1) - 7'd1) begin // [R7]
                        s_d.word_r = nsh & word_mask(wb);
                        got_right = 1'b1;
                    end
                end
            endcase
            s_d.bitcnt = cnt;
            if (got_right) begin // [R25]
                s_d.out_valid = 1'b1;
                s_d.out_l = s_d.word_l;
                s_d.out_r = s_d.word_r;
            end
        end

        // volume updates, gated by zero cross when enabled
        if (s_q.pend_l && (!s_q.lvol[VOL_ZC_BIT] || s_q.zl_lvl)) begin // [R19]
            s_d.app_l = s_q.lvol[6:0];
            s_d.pend_l = 1'b0;
        end
        if (s_q.pend_r && (!s_q.rvol[VOL_ZC_BIT] || s_q.zr_lvl)) begin // [R19]
            s_d.app_r = s_q.rvol[6:0];
            s_d.pend_r = 1'b0;
        end

        // apb slave, one wait state
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        wr = psel && penable && s_q.pready && pwrite;
        rd = psel && penable && !s_q.pready && !pwrite;
        s_d.prdata = 32'h0000_0000;
        if (s_d.pready) begin
            unique case (paddr)
                ADDR_LEFT_VOL:  s_d.prdata = {23'h0, s_q.lvol};
                ADDR_RIGHT_VOL: s_d.prdata = {23'h0, s_q.rvol};
                ADDR_SRATE:     s_d.prdata = {23'h0, s_q.srate};
                ADDR_FORMAT:    s_d.prdata = {25'h0, s_q.fmt};
                ADDR_SOFT_RST:  s_d.prdata = 32'h0000_0000;
                ADDR_LEFT_WORD: s_d.prdata = s_q.out_l;
                ADDR_RIGHT_WRD: s_d.prdata = s_q.out_r;
                ADDR_STATUS:    s_d.prdata = {14'h0, s_q.pend_r, s_q.pend_l,
                                              1'b0, s_q.app_r,
                                              1'b0, s_q.app_l};
                ADDR_PERIOD:    s_d.prdata = {16'h0,
                                              sample_period(s_q.srate)};
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
            if (!rd) s_d.prdata = 32'h0000_0000;
        end
        if (wr) begin
            unique case (paddr)
                ADDR_LEFT_VOL: begin
                    s_d.lvol = pwdata[8:0];
                    s_d.pend_l = 1'b1;
                    if (pwdata[VOL_LINK_BIT]) begin // [R20]
                        s_d.rvol = pwdata[8:0];
                        s_d.pend_r = 1'b1;
                    end
                end
                ADDR_RIGHT_VOL: begin
                    s_d.rvol = pwdata[8:0];
                    s_d.pend_r = 1'b1;
                    if (pwdata[VOL_LINK_BIT]) begin // [R20]
                        s_d.lvol = pwdata[8:0];
                        s_d.pend_l = 1'b1;
                    end
                end
                ADDR_SRATE:  s_d.srate = pwdata[8:0] & SRATE_MASK; // [R10]
                ADDR_FORMAT: s_d.fmt = pwdata[6:0] & FORMAT_MASK;
                ADDR_SOFT_RST: begin
                    s_d.lvol = VOL_RESET;
                    s_d.rvol = VOL_RESET;
                    s_d.srate = SRATE_RESET;
                    s_d.fmt = FORMAT_RESET;
                    s_d.app_l = VOL_RESET[6:0];
                    s_d.app_r = VOL_RESET[6:0];
                    s_d.pend_l = 1'b0;
                    s_d.pend_r = 1'b0;
                    s_d.bitcnt = 7'd0;
                    s_d.shift = 32'h0000_0000;
                    s_d.word_l = 32'h0000_0000;
                    s_d.word_r = 32'h0000_0000;
                    s_d.out_l = 32'h0000_0000;
                    s_d.out_r = 32'h0000_0000;
                    s_d.out_valid = 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.lvol <= VOL_RESET;
            s_q.rvol <= VOL_RESET;
            s_q.srate <= SRATE_RESET; // [R10]
            s_q.fmt <= FORMAT_RESET;
            s_q.app_l <= VOL_RESET[6:0];
            s_q.app_r <= VOL_RESET[6:0];
            s_q.gen_fs <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs from state flops; bclk_oe_n and frame_sync_oe_n invert a flop, mute compares the applied gain
    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign serial_out.bclk = s_q.gen_bclk;
    assign serial_out.bclk_oe_n = ~s_q.fmt[FMT_MS_BIT]; // [R2]
    assign serial_out.frame_sync = s_q.gen_fs;
    assign serial_out.frame_sync_oe_n = ~s_q.fmt[FMT_MS_BIT];
    assign sample_out.valid = s_q.out_valid;
    assign sample_out.left = s_q.out_l;
    assign sample_out.right = s_q.out_r;
    assign left_headphone_output.gain = s_q.app_l; // [R17]
    assign left_headphone_output.mute = s_q.app_l < VOL_MUTE_LIMIT; // [R18]
    assign right_headphone_output.gain = s_q.app_r; // [R17]
    assign right_headphone_output.mute = s_q.app_r < VOL_MUTE_LIMIT; // [R18]
    assign clock_out_div2 = s_q.clkdiv;
    assign clock_output_divider = s_q.srate[SR_CLKDIV_BIT]; // [R11]
endmodule

/* tb/audio_rx_props.sv */
// assertions on the serial audio receiver top ports
// assumes binding onto stereo_dac_serial_audio_rx, one clock domain
`timescale 1ns/1ps
module audio_rx_props (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     arst_n,
    // apb
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [7:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // outputs
    input wire audio_rx_pkg::serial_out_t serial_out,
    input wire audio_rx_pkg::sample_t    sample_out,
    input wire audio_rx_pkg::headphone_t left_headphone_output,
    input wire audio_rx_pkg::headphone_t right_headphone_output,
    input wire logic                     clock_output_divider
);
    import audio_rx_pkg::*;
    logic wr_done;
    logic wr_srate;
    logic wr_rst;
    logic wr_ms;
    logic wr_zero;
    assign wr_done  = pready && psel && penable && pwrite;
    assign wr_srate = wr_done && paddr == ADDR_SRATE;
    assign wr_rst   = wr_done && paddr == ADDR_SOFT_RST;
    assign wr_ms    = wr_done && paddr == ADDR_FORMAT && pwdata[FMT_MS_BIT];
    assign wr_zero  = wr_done && pwdata[8:0] == 9'h000;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_answer: assert property (s_access |=> s_answer)
        else $error("apb answer not one cycle after access");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside
        {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20}))
        else $error("slave error does not match address map");
    a_divider_src: assert property ($changed(clock_output_divider) |->
        $past(wr_srate) || $past(wr_rst))
        else $error("clock divider changed without a write");
    a_mute_left: assert property ($past(wr_zero, 2) &&
        $past(paddr, 2) == ADDR_LEFT_VOL |-> left_headphone_output.mute)
        else $error("left not muted after zero write");
    a_mute_right: assert property ($past(wr_zero, 2) &&
        $past(paddr, 2) == ADDR_RIGHT_VOL |-> right_headphone_output.mute)
        else $error("right not muted after zero write");
    a_valid_pulse: assert property (sample_out.valid |=>
        !sample_out.valid [*8])
        else $error("sample valid not a single pulse per frame");
    a_words_frame: assert property ($changed(sample_out.left) ||
        $changed(sample_out.right) |-> sample_out.valid || $past(wr_rst))
        else $error("sample words changed outside a frame");
    a_oe_master: assert property ($fell(serial_out.bclk_oe_n) |->
        $past(wr_ms) || $past(wr_ms, 2))
        else $error("bit clock driven without master setting");
endmodule

bind stereo_dac_serial_audio_rx audio_rx_props props (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .serial_out(serial_out), .sample_out(sample_out),
    .left_headphone_output(left_headphone_output),
    .right_headphone_output(right_headphone_output),
    .clock_output_divider(clock_output_divider));

/* tb/host_audio_port.sv */
// host serial port model sending one stereo frame per call
// assumes device in slave mode; bit clock stands still between frames
`timescale 1ns/1ps
module host_audio_port (
    // master clock and serial pins
    input  wire logic                clk,
    output audio_rx_pkg::serial_in_t line
);
    import audio_rx_pkg::*;
    initial line = '{bclk: 1'b0, frame_sync: 1'b1, data: 1'b0};
    // one bit: change while low, device samples on the rise
    task automatic slot(input logic s, input logic d);
        line.bclk       <= 1'b0;
        line.frame_sync <= s;
        line.data       <= d;
        repeat (4) @(posedge clk);
        line.bclk <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic send(input logic [1:0] fmt, input int w, input logic ph,
                        input logic [31:0] l, input logic [31:0] r);
        int   j;
        logic d;
        logic s;
        d = 1'b0;
        slot(fmt == FMT_DSP ? 1'b1 : ~ph, d);
        for (int i = 0; i < 64; i++) begin
            case (fmt)
                FMT_LEFT_J:  j = i % 32;
                FMT_I2S:     j = i % 32 - 1;
                FMT_RIGHT_J: j = i % 32 - (32 - w);
                default:     j = i;
            endcase
            s = (i >= 32) ^ ph;
            if (fmt == FMT_DSP) begin
                s = (i != 0);
                d = j < w ? l[w-1-j] : j < 2*w ? r[2*w-1-j] : ~d;
            end else begin
                d = j >= 0 && j < w ? (i < 32 ? l[w-1-j] : r[w-1-j]) : ~d;
            end
            slot(s, d);
        end
        slot(ph, ~d);
        slot(ph, d);
        line.bclk <= 1'b0;
        line.data <= ~d;
    endtask
endmodule

/* tb/test_stereo_dac_serial_audio_rx.sv */
// bench for the serial audio receiver: registers, volume, clocks, frames
// assumes host_audio_port drives the serial pins in slave mode
`timescale 1ns/1ps
module test_stereo_dac_serial_audio_rx;
    import audio_rx_pkg::*;
    logic        clk = 0, arst_n = 0, lz = 1, rz = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, lw, rw, el, er;
    logic        pready, pslverr, sl_err, ph, cdiv, cdiv2;
    logic [1:0]  wl;
    serial_in_t  sin;
    serial_out_t sout;
    sample_t     smp;
    headphone_t  lhp, rhp;
    int          errors = 0, checks_done = 0, seed = 32'h27ce93c9, w, t;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (smp.valid === 1'b1) begin
            lw <= smp.left;
            rw <= smp.right;
        end
    end
    host_audio_port host (.clk(clk), .line(sin));
    stereo_dac_serial_audio_rx dut (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .serial_in(sin), .serial_out(sout),
        .left_zero_near(lz), .right_zero_near(rz), .sample_out(smp),
        .left_headphone_output(lhp), .right_headphone_output(rhp),
        .clock_out_div2(cdiv2), .clock_output_divider(cdiv));
    function automatic logic [31:0] word_exp(logic [31:0] v, int n);
        return v & ((64'h1 << n) - 1);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat   = prdata;
        sl_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        apb(0, ADDR_SRATE, 0);
        chk(rdat, 32'(SRATE_RESET));
        apb(0, ADDR_FORMAT, 0);
        chk(rdat, 32'(FORMAT_RESET));
        apb(0, ADDR_LEFT_VOL, 0);
        chk(rdat, 32'(VOL_RESET));
        apb(0, 8'h24, 0);
        chk(rdat, 0);
        chk(sl_err, 1);
        repeat (6) begin
            t = $random(seed);
            apb(1, ADDR_SRATE, t);
            apb(0, ADDR_SRATE, 0);
            chk(rdat, t & SRATE_MASK);
            chk(cdiv, t[SR_CLKDIV_BIT]);
        end
        $display("register test done");
        t = 'h30 + ($random(seed) & 'h3f);
        apb(1, ADDR_LEFT_VOL, 32'h100 | t);
        repeat (10) @(posedge clk);
        chk({lhp.gain, rhp.gain}, {t[6:0], t[6:0]});
        apb(1, ADDR_RIGHT_VOL, 0);
        repeat (10) @(posedge clk);
        chk({rhp.mute, lhp.gain}, {1'b1, t[6:0]});
        lz <= 1'b0;
        apb(1, ADDR_LEFT_VOL, 32'h0ca);
        repeat (30) @(posedge clk);
        chk(lhp.gain, t);
        lz <= 1'b1;
        repeat (10) @(posedge clk);
        chk(lhp.gain, 'h4a);
        apb(1, ADDR_LEFT_VOL, 0);
        $display("volume test done");
        apb(1, ADDR_SRATE, 0);
        apb(1, ADDR_FORMAT, 32'h41);
        repeat (8) @(posedge clk);
        chk(sout.bclk_oe_n, 0);
        w = 0;
        repeat (16) begin
            ph = sout.bclk;
            @(posedge clk);
            w += (ph !== sout.bclk);
        end
        chk(w, 8);
        ph = cdiv2;
        @(posedge clk);
        chk(cdiv2, !ph);
        $display("master clock test done");
        for (int f = 0; f < 4; f++) begin
            wl = ($random(seed) & 1) ? WL_24 : WL_16;
            w  = (wl == WL_24) ? 24 : 16;
            ph = $random(seed);
            el = $random(seed);
            er = $random(seed);
            apb(1, ADDR_FORMAT, {27'h0, ph, wl, f[1:0]});
            @(posedge clk);
            chk(sout.bclk_oe_n, 1);
            host.send(f[1:0], w, ph, el, er);
            repeat (20) @(posedge clk);
            chk(lw, word_exp(el, w));
            chk(rw, word_exp(er, w));
        end
        $display("serial format test done");
        apb(1, ADDR_SRATE, 'hff);
        apb(1, ADDR_SOFT_RST, 1);
        apb(0, ADDR_SRATE, 0);
        chk(rdat, 32'(SRATE_RESET));
        $display("soft reset test done");
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule
